/* File: rtl/bpcr_pkg.sv */
// Constants for the battery profile and charger register bank.
// Assumes a single clock domain; the host bus arrives on plain pins.
package bpcr_pkg;
  localparam int BYTE_W = 8;
  localparam int MV_W = 13;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;

  // Slave addresses of the command device and of the status mirror.
  localparam logic [6:0] CMD_ADDR = 7'h6b;
  localparam logic [6:0] MIRROR_ADDR = 7'h69;

  // Register locations.
  localparam logic [7:0] REG_CHEM = 8'h07;
  localparam logic [7:0] REG_CHG_CTRL = 8'h1d;
  localparam logic [7:0] REG_CHG_STATE = 8'h20;
  localparam logic [7:0] REG_PWR_MODE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Chemistry codes, first board variant.
  localparam logic [7:0] CODE_STD_LIPO = 8'h53;
  localparam logic [7:0] CODE_STD_LFP = 8'h46;
  localparam logic [7:0] CODE_STD_LION = 8'h49;
  localparam logic [7:0] CODE_STD_NMH = 8'h48;
  localparam logic [7:0] CODE_STD_SLA = 8'h4c;
  // Chemistry codes, extended board variant.
  localparam logic [7:0] CODE_EXT_LIPO = 8'h50;
  localparam logic [7:0] CODE_EXT_LFP = 8'h51;
  localparam logic [7:0] CODE_EXT_LION = 8'h4f;
  localparam logic [7:0] CODE_EXT_NMH = 8'h4d;
  localparam logic [7:0] CODE_EXT_SLA = 8'h41;

  // Charger control, charger state and powering mode values.
  localparam logic [7:0] CTRL_DISABLE = 8'h00;
  localparam logic [7:0] CTRL_AUTO = 8'h01;
  localparam logic [7:0] STATE_OFF = 8'h00;
  localparam logic [7:0] STATE_ON = 8'h01;
  localparam logic [7:0] MODE_CABLE = 8'h01;
  localparam logic [7:0] MODE_BATT = 8'h02;

  // Thresholds in millivolts: 3500, 2950, 3400, 3200, 3100, 4200, 3600.
  localparam logic [MV_W-1:0] LOW_LIPO = 13'hdac;
  localparam logic [MV_W-1:0] LOW_LFP = 13'hb86;
  localparam logic [MV_W-1:0] LOW_LION = 13'hd48;
  localparam logic [MV_W-1:0] LOW_NMH = 13'hc80;
  localparam logic [MV_W-1:0] LOW_SLA = 13'hc1c;
  localparam logic [MV_W-1:0] FULL_COMMON = 13'h1068;
  localparam logic [MV_W-1:0] FULL_LFP = 13'he10;

  typedef enum logic [2:0] {
    CHEM_LIPO = 3'h0,
    CHEM_LFP = 3'h1,
    CHEM_LION = 3'h2,
    CHEM_NMH = 3'h3,
    CHEM_SLA = 3'h4,
    CHEM_NONE = 3'h5
  } bpcr_chem_type;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_PTR = 9'h008,
    S_PACK = 9'h010,
    S_WDAT = 9'h020,
    S_WACK = 9'h040,
    S_RDAT = 9'h080,
    S_RACK = 9'h100
  } bpcr_state_type;
endpackage : bpcr_pkg

/* File: rtl/bpcr_regs.sv */
// Battery chemistry, charger control and charger state registers behind
// a byte-wide two-wire serial slave answering at two addresses.
// Assumes scl/sda and the cable, request and flow pins are asynchronous to clk,
// that firmware_updated is synchronous to clk, and that clk is well above sixteen times the serial bit rate.
//
// Notes on behaviour
// [R01] Chemistry register at 0x07 of the command slave, read and write.
// [R02] First variant accepts codes 0x53, 0x46, 0x49, 0x48, 0x4c.
// [R03] Extended variant accepts codes 0x50, 0x51, 0x4f, 0x4d, 0x41.
// [R04] Host writes only codes listed for its own board variant.
// [R05] Lithium polymer 3.5/4.2 V, iron phosphate 2.95/3.6 V thresholds.
// [R06] Lithium ion 3.4, nickel hydride 3.2, lead acid 3.1 V low; 4.2 V full.
// [R07] Firmware update restores the board default chemistry.
// [R08] Read-only charger state at mirror 0x20: 0x00 off, 0x01 on.
// [R09] Charge lamp lights only while current flows into the battery.
// [R10] Device switches charger automatically and shows it in the state.
// [R11] Charger control at 0x1d: 0x00 disables, 0x01 returns to automatic.
// [R12] Charger control writes take effect only under cable power.
// [R13] Powering mode at mirror 0x00 reads 0x01 cable, 0x02 battery.
// [R14] An unlisted chemistry code leaves the stored chemistry unchanged.
// [R15] Writes to the charger state register are ignored.
`timescale 1ns/1ps
module bpcr_regs #(
  parameter bit EXT_BOARD = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Host serial bus.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Board conditions.
  input wire logic cable_powered,
  input wire logic charge_request,
  input wire logic charge_current_flow,
  input wire logic firmware_updated,
  // Charger and battery profile.
  output logic charger_on,
  output logic charge_current_lamp,
  output logic [bpcr_pkg::MV_W-1:0] low_thresh_mv,
  output logic [bpcr_pkg::MV_W-1:0] full_thresh_mv
);
  import bpcr_pkg::*;

  localparam logic [7:0] DEFAULT_CHEM =
    EXT_BOARD ? CODE_EXT_LIPO : CODE_STD_LIPO;

  function automatic bpcr_chem_type chem_kind(input logic [7:0] code);
    bpcr_chem_type k;
    k = CHEM_NONE;
    if (EXT_BOARD) begin
      case (code)
        CODE_EXT_LIPO: k = CHEM_LIPO;
        CODE_EXT_LFP: k = CHEM_LFP;
        CODE_EXT_LION: k = CHEM_LION;
        CODE_EXT_NMH: k = CHEM_NMH;
        CODE_EXT_SLA: k = CHEM_SLA;
        default: k = CHEM_NONE;
      endcase
    end else begin
      case (code)
        CODE_STD_LIPO: k = CHEM_LIPO;
        CODE_STD_LFP: k = CHEM_LFP;
        CODE_STD_LION: k = CHEM_LION;
        CODE_STD_NMH: k = CHEM_NMH;
        CODE_STD_SLA: k = CHEM_SLA;
        default: k = CHEM_NONE;
      endcase
    end
    return k;
  endfunction : chem_kind

  function automatic logic [MV_W-1:0] low_mv(input bpcr_chem_type k);
    logic [MV_W-1:0] v;
    case (k)
      CHEM_LFP: v = LOW_LFP;
      CHEM_LION: v = LOW_LION;
      CHEM_NMH: v = LOW_NMH;
      CHEM_SLA: v = LOW_SLA;
      default: v = LOW_LIPO;
    endcase
    return v;
  endfunction : low_mv

  function automatic logic [7:0] read_byte(input logic mirror,
      input logic [7:0] ptr, input logic [7:0] chem,
      input logic [7:0] ctrl, input logic chg, input logic [7:0] mode);
    logic [7:0] d;
    d = READ_UNMAPPED;
    if (mirror) begin
      if (ptr == REG_CHG_STATE) begin
        d = chg ? STATE_ON : STATE_OFF;
      end else if (ptr == REG_PWR_MODE) begin
        d = mode;
      end
    end else begin
      if (ptr == REG_CHEM) begin
        d = chem;
      end else if (ptr == REG_CHG_CTRL) begin
        d = ctrl;
      end
    end
    return d;
  endfunction : read_byte

  // Input synchronisers; the third stage of scl and sda feeds edge logic.
  logic scl_meta, scl_sync, scl_last;
  logic sda_meta, sda_sync, sda_last;
  logic cable_meta, cable_sync;
  logic req_meta, req_sync;
  logic flow_meta, flow_sync;

  always_ff @(posedge clk) begin
    scl_meta <= scl_in;
    scl_sync <= scl_meta;
    scl_last <= scl_sync;
    sda_meta <= sda_in;
    sda_sync <= sda_meta;
    sda_last <= sda_sync;
    cable_meta <= cable_powered;
    cable_sync <= cable_meta;
    req_meta <= charge_request;
    req_sync <= req_meta;
    flow_meta <= charge_current_flow;
    flow_sync <= flow_meta;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_sync & ~scl_last;
  assign scl_fall = ~scl_sync & scl_last;
  assign bus_start = scl_sync & scl_last & sda_last & ~sda_sync;
  assign bus_stop = scl_sync & scl_last & ~sda_last & sda_sync;

  // Serial slave state.
  bpcr_state_type state_reg, state_next;
  logic [7:0] sh_reg, sh_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic mirror_reg, mirror_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic drive_reg, drive_next;
  logic wr_stb;
  logic [7:0] rd_byte;

  // Register bank state.
  logic [7:0] chem_reg, chem_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] mode_reg, mode_next;
  logic chg_on_reg, chg_on_next;
  logic lamp_reg, lamp_next;
  logic [MV_W-1:0] low_reg, low_next;
  logic [MV_W-1:0] full_reg, full_next;

  assign rd_byte = read_byte(mirror_reg, ptr_reg, chem_reg, ctrl_reg,
                             chg_on_reg, mode_reg); // [R08] [R13]

  // Bits are sampled on scl rise; sda changes only after scl falls, so a
  // byte ends on the fall that follows the eighth rise.
  always_comb begin
    state_next = state_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    mirror_next = mirror_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    drive_next = drive_reg;
    wr_stb = 1'b0;
    if (bus_start) begin
      state_next = S_ADDR;
      cnt_next = '0;
      drive_next = 1'b0;
    end else if (bus_stop) begin
      state_next = S_IDLE;
      drive_next = 1'b0;
    end else if (scl_rise) begin
      if (state_reg inside {S_ADDR, S_PTR, S_WDAT}) begin
        sh_next = {sh_reg[6:0], sda_sync};
      end
      if (state_reg inside {S_ADDR, S_PTR, S_WDAT, S_RDAT}) begin
        cnt_next = cnt_reg + 4'h1;
      end
      if (state_reg == S_RACK) begin
        nack_next = sda_sync;
      end
    end else if (scl_fall) begin
      case (state_reg)
        S_ADDR: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            if (sh_reg[7:1] == CMD_ADDR || sh_reg[7:1] == MIRROR_ADDR) begin
              mirror_next = (sh_reg[7:1] == MIRROR_ADDR);
              rw_next = sh_reg[0];
              state_next = S_AACK;
              drive_next = 1'b1;
            end else begin
              state_next = S_IDLE;
            end
          end
        end
        S_AACK: begin
          cnt_next = '0;
          if (rw_reg) begin
            state_next = S_RDAT;
            sh_next = rd_byte;
            drive_next = ~rd_byte[7];
          end else begin
            state_next = S_PTR;
            drive_next = 1'b0;
          end
        end
        S_PTR: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            ptr_next = sh_reg;
            state_next = S_PACK;
            drive_next = 1'b1;
          end
        end
        S_PACK, S_WACK: begin
          state_next = S_WDAT;
          cnt_next = '0;
          drive_next = 1'b0;
        end
        S_WDAT: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            wr_stb = 1'b1;
            ptr_next = ptr_reg + 8'h01;
            state_next = S_WACK;
            drive_next = 1'b1;
          end
        end
        S_RDAT: begin
          if (cnt_reg == BITS_PER_BYTE) begin
            ptr_next = ptr_reg + 8'h01;
            state_next = S_RACK;
            drive_next = 1'b0;
          end else begin
            sh_next = {sh_reg[6:0], 1'b0};
            drive_next = ~sh_reg[6];
          end
        end
        S_RACK: begin
          cnt_next = '0;
          if (nack_reg) begin
            state_next = S_IDLE;
            drive_next = 1'b0;
          end else begin
            state_next = S_RDAT;
            sh_next = rd_byte;
            drive_next = ~rd_byte[7];
          end
        end
        default: begin
          state_next = S_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      mirror_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
      mirror_reg <= mirror_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      drive_reg <= drive_next;
    end
  end

  // A firmware update outranks a chemistry write landing in the same cycle;
  // it must not swallow a charger control write, so that path is separate.
  always_comb begin
    chem_next = chem_reg;
    ctrl_next = ctrl_reg;
    mode_next = cable_sync ? MODE_CABLE : MODE_BATT; // [R13]
    chg_on_next = (ctrl_reg == CTRL_AUTO) && req_sync; // [R10] [R11]
    lamp_next = chg_on_reg && flow_sync; // [R09]
    low_next = low_mv(chem_kind(chem_reg)); // [R05] [R06]
    full_next = (chem_kind(chem_reg) == CHEM_LFP) ? FULL_LFP : FULL_COMMON;
    if (firmware_updated) begin
      chem_next = DEFAULT_CHEM; // [R07]
    end else if (wr_stb && !mirror_reg && ptr_reg == REG_CHEM &&
                 chem_kind(sh_reg) != CHEM_NONE) begin
      // Unlisted codes would pick an unknown profile, so they are dropped.
      chem_next = sh_reg; // [R01] [R02] [R03] [R14]
    end
    // Mirror writes match neither branch, so they change nothing.
    if (wr_stb && !mirror_reg && ptr_reg == REG_CHG_CTRL && // [R15]
        mode_reg == MODE_CABLE &&
        (sh_reg == CTRL_DISABLE || sh_reg == CTRL_AUTO)) begin
      ctrl_next = sh_reg; // [R11] [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chem_reg <= DEFAULT_CHEM;
      ctrl_reg <= CTRL_AUTO;
      mode_reg <= MODE_BATT;
      chg_on_reg <= 1'b0;
      lamp_reg <= 1'b0;
      low_reg <= LOW_LIPO;
      full_reg <= FULL_COMMON;
    end else begin
      chem_reg <= chem_next;
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      chg_on_reg <= chg_on_next;
      lamp_reg <= lamp_next;
      low_reg <= low_next;
      full_reg <= full_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_reg;
  assign charger_on = chg_on_reg;
  assign charge_current_lamp = lamp_reg;
  assign low_thresh_mv = low_reg;
  assign full_thresh_mv = full_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence chem_write_s;
    wr_stb && !mirror_reg && ptr_reg == REG_CHEM && !firmware_updated;
  endsequence
  sequence ctrl_write_s;
    wr_stb && !mirror_reg && ptr_reg == REG_CHG_CTRL;
  endsequence

  chem_legal_a: assert property ( // [R02] [R03]
    chem_kind(chem_reg) != CHEM_NONE)
    else $error("chemistry register holds an unlisted code");
  chem_store_a: assert property ( // [R01]
    chem_write_s ##0 chem_kind(sh_reg) != CHEM_NONE
    |=> chem_reg == $past(sh_reg))
    else $error("listed chemistry code was not stored");
  chem_keep_a: assert property ( // [R14]
    chem_write_s ##0 chem_kind(sh_reg) == CHEM_NONE |=> $stable(chem_reg))
    else $error("unlisted chemistry code changed the register");
  fw_restore_a: assert property ( // [R07]
    firmware_updated |=> chem_reg == DEFAULT_CHEM)
    else $error("firmware update did not restore default chemistry");
  lfp_thresh_a: assert property ( // [R05]
    chem_kind(chem_reg) == CHEM_LFP
    |=> low_thresh_mv == LOW_LFP && full_thresh_mv == FULL_LFP)
    else $error("iron phosphate thresholds wrong");
  sla_thresh_a: assert property ( // [R06]
    chem_kind(chem_reg) == CHEM_SLA
    |=> low_thresh_mv == LOW_SLA && full_thresh_mv == FULL_COMMON)
    else $error("lead acid thresholds wrong");
  charger_auto_a: assert property ( // [R10] [R11]
    ctrl_reg == CTRL_AUTO && req_sync |=> charger_on)
    else $error("charger not switched on in automatic mode");
  ctrl_disable_a: assert property ( // [R11]
    ctrl_write_s ##0 (mode_reg == MODE_CABLE && sh_reg == CTRL_DISABLE)
    |=> ctrl_reg == CTRL_DISABLE ##1 !charger_on)
    else $error("disable write did not stop the charger");
  ctrl_battery_a: assert property ( // [R12]
    ctrl_write_s ##0 mode_reg != MODE_CABLE |=> $stable(ctrl_reg))
    else $error("charger control changed under battery power");
  lamp_cause_a: assert property ( // [R09]
    charge_current_lamp |-> $past(charger_on))
    else $error("charge lamp lit while charger off");
  state_read_a: assert property ( // [R08]
    mirror_reg && ptr_reg == REG_CHG_STATE
    |-> rd_byte == (charger_on ? STATE_ON : STATE_OFF))
    else $error("charger state reads wrong value");
  mode_batt_a: assert property ( // [R13]
    !cable_sync [*2] |=> mode_reg == MODE_BATT && $past(mode_reg) == MODE_BATT)
    else $error("powering mode not battery");
  mirror_wr_a: assert property ( // [R15]
    wr_stb && mirror_reg |=> $stable(ctrl_reg) && $stable(charger_on) == 1'b1
      || $past(req_sync) != $past(req_sync, 2))
    else $error("mirror write disturbed the charger state");
endmodule : bpcr_regs

/* File: test/bpcr_host.sv */
// Host side model: a two-wire serial master that reads and writes bytes.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module bpcr_host #(
  parameter int QTR = 8
) (
  // Clock.
  input wire logic clk,
  // Serial bus.
  input wire logic sda_line,
  output logic scl_out,
  output logic sda_low
);
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Also serves as repeated start, since it first releases the data line.
  task automatic start_cond();
    @(posedge clk);
    sda_low <= 1'b0;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    sda_low <= 1'b1;
    tick(QTR);
    scl_out <= 1'b0;
    tick(QTR);
  endtask : start_cond

  // Data moves only while the clock is low; sampled mid-way through high.
  task automatic bit_xfer(input logic tx, output logic rx);
    sda_low <= !tx;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    rx = sda_line;
    tick(QTR);
    scl_out <= 1'b0;
    tick(QTR);
  endtask : bit_xfer

  task automatic byte_xfer(input logic [7:0] tx, input logic last,
                           output logic [7:0] rx, output logic ninth);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(last, ninth);
  endtask : byte_xfer

  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    sda_low <= 1'b0;
    tick(2 * QTR);
  endtask : stop_cond

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_cond();
    byte_xfer({dev, 1'b0}, 1'b1, rx, a0);
    byte_xfer(ptr, 1'b1, rx, a1);
    byte_xfer(data, 1'b1, rx, a2);
    stop_cond();
    acked = !(a0 | a1 | a2);
  endtask : write_reg

  // Single byte read, closed by a not-acknowledge from the master.
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data, output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2, nk;
    start_cond();
    byte_xfer({dev, 1'b0}, 1'b1, rx, a0);
    byte_xfer(ptr, 1'b1, rx, a1);
    start_cond();
    byte_xfer({dev, 1'b1}, 1'b1, rx, a2);
    byte_xfer(8'hff, 1'b1, data, nk);
    stop_cond();
    acked = !(a0 | a1 | a2);
  endtask : read_reg
endmodule : bpcr_host

/* File: test/test_bpcr_regs.sv */
// Self-checking bench for the register bank, both board variants.
// Assumes bpcr_pkg and bpcr_host are compiled first.
`timescale 1ns/1ps
`define CHECK(g, e) cmp(16'(g), 16'(e))
module test_bpcr_regs;
  import bpcr_pkg::*;
  localparam int TIMEOUT = 80000;
  logic clk = 1'b0;
  logic sys_rst;
  logic cable_powered, charge_request, charge_current_flow;
  logic firmware_updated;
  logic charger_on, lamp;
  wire logic [1:0] scl, sda_low, sda_out, sda_oe_n;
  wire logic [1:0] sda_line;
  wire logic [MV_W-1:0] low_mv [2];
  wire logic [MV_W-1:0] full_mv [2];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] codes [2][5] = '{
    '{CODE_STD_LIPO, CODE_STD_LFP, CODE_STD_LION, CODE_STD_NMH, CODE_STD_SLA},
    '{CODE_EXT_LIPO, CODE_EXT_LFP, CODE_EXT_LION, CODE_EXT_NMH, CODE_EXT_SLA}};
  logic [MV_W-1:0] low_tab [5] = '{LOW_LIPO, LOW_LFP, LOW_LION, LOW_NMH,
                                   LOW_SLA};
  logic [MV_W-1:0] full_tab [5] = '{FULL_COMMON, FULL_LFP, FULL_COMMON,
                                    FULL_COMMON, FULL_COMMON};

  // Pull-up on each data line; any party pulling low wins.
  assign sda_line[0] = !sda_low[0] && (sda_oe_n[0] || sda_out[0]);
  assign sda_line[1] = !sda_low[1] && (sda_oe_n[1] || sda_out[1]);

  always #5 clk = ~clk;

  bpcr_host bpcr_host_i (.clk(clk), .sda_line(sda_line[0]),
    .scl_out(scl[0]), .sda_low(sda_low[0]));
  bpcr_host bpcr_host_ext_i (.clk(clk), .sda_line(sda_line[1]),
    .scl_out(scl[1]), .sda_low(sda_low[1]));

  bpcr_regs #(.EXT_BOARD(1'b0)) bpcr_regs_i (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl[0]), .sda_in(sda_line[0]), .sda_out(sda_out[0]),
    .sda_oe_n(sda_oe_n[0]), .cable_powered(cable_powered),
    .charge_request(charge_request),
    .charge_current_flow(charge_current_flow),
    .firmware_updated(firmware_updated), .charger_on(charger_on),
    .charge_current_lamp(lamp), .low_thresh_mv(low_mv[0]),
    .full_thresh_mv(full_mv[0]));
  bpcr_regs #(.EXT_BOARD(1'b1)) bpcr_regs_ext_i (.clk(clk),
    .sys_rst(sys_rst), .scl_in(scl[1]), .sda_in(sda_line[1]),
    .sda_out(sda_out[1]), .sda_oe_n(sda_oe_n[1]),
    .cable_powered(cable_powered), .charge_request(charge_request),
    .charge_current_flow(charge_current_flow),
    .firmware_updated(firmware_updated), .charger_on(),
    .charge_current_lamp(), .low_thresh_mv(low_mv[1]),
    .full_thresh_mv(full_mv[1]));

  task automatic stop_test();
    $display("Checks done %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  // Every transfer must be acknowledged, refused data included.
  task automatic wr(input int v, input logic [6:0] dev,
                    input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    if (v == 0) begin
      bpcr_host_i.write_reg(dev, ptr, data, ok);
    end else begin
      bpcr_host_ext_i.write_reg(dev, ptr, data, ok);
    end
    `CHECK(ok, 1'b1);
  endtask : wr

  task automatic rd_chk(input int v, input logic [6:0] dev,
                        input logic [7:0] ptr, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    if (v == 0) begin
      bpcr_host_i.read_reg(dev, ptr, d, ok);
    end else begin
      bpcr_host_ext_i.read_reg(dev, ptr, d, ok);
    end
    `CHECK(ok, 1'b1);
    `CHECK(d, exp);
  endtask : rd_chk

  // A hang anywhere in the bus model ends the run as a failure.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    sys_rst = 1'b1;
    cable_powered = 1'b0;
    charge_request = 1'b0;
    charge_current_flow = 1'b0;
    firmware_updated = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int v = 0; v < 2; v++) begin
      `CHECK(low_mv[v], LOW_LIPO);
      `CHECK(full_mv[v], FULL_COMMON);
      rd_chk(v, CMD_ADDR, REG_CHEM, codes[v][0]);
      for (int k = 1; k < 6; k++) begin
        wr(v, CMD_ADDR, REG_CHEM, codes[v][k % 5]);
        rd_chk(v, CMD_ADDR, REG_CHEM, codes[v][k % 5]);
        `CHECK(low_mv[v], low_tab[k % 5]);
        `CHECK(full_mv[v], full_tab[k % 5]);
      end
      // A code of the other variant is foreign here and must not stick.
      wr(v, CMD_ADDR, REG_CHEM, codes[1 - v][1]);
      rd_chk(v, CMD_ADDR, REG_CHEM, codes[v][0]);
      `CHECK(full_mv[v], FULL_COMMON);
      wr(v, CMD_ADDR, REG_CHEM, codes[v][1]);
    end
    firmware_updated <= 1'b1;
    @(posedge clk);
    firmware_updated <= 1'b0;
    repeat (3) @(posedge clk);
    for (int v = 0; v < 2; v++) begin
      `CHECK(low_mv[v], LOW_LIPO);
      rd_chk(v, CMD_ADDR, REG_CHEM, codes[v][0]);
    end
    charge_request <= 1'b1;
    rd_chk(0, MIRROR_ADDR, REG_PWR_MODE, MODE_BATT);
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_ON);
    `CHECK(charger_on, 1'b1);
    `CHECK(lamp, 1'b0);
    charge_current_flow <= 1'b1;
    wr(0, CMD_ADDR, REG_CHG_CTRL, CTRL_DISABLE);
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_ON);
    `CHECK(lamp, 1'b1);
    cable_powered <= 1'b1;
    rd_chk(0, MIRROR_ADDR, REG_PWR_MODE, MODE_CABLE);
    wr(0, CMD_ADDR, REG_CHG_CTRL, CTRL_DISABLE);
    rd_chk(0, CMD_ADDR, REG_CHG_CTRL, CTRL_DISABLE);
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_OFF);
    `CHECK(charger_on, 1'b0);
    `CHECK(lamp, 1'b0);
    wr(0, MIRROR_ADDR, REG_CHG_STATE, STATE_ON);
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_OFF);
    // Only the two control values are kept; anything else leaves it alone.
    wr(0, CMD_ADDR, REG_CHG_CTRL, 8'h05);
    rd_chk(0, CMD_ADDR, REG_CHG_CTRL, CTRL_DISABLE);
    rd_chk(0, MIRROR_ADDR, REG_CHEM, READ_UNMAPPED);
    wr(0, CMD_ADDR, REG_CHG_CTRL, CTRL_AUTO);
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_ON);
    charge_request <= 1'b0;
    rd_chk(0, MIRROR_ADDR, REG_CHG_STATE, STATE_OFF);
    stop_test();
  end
endmodule : test_bpcr_regs
